/* File: pkg/ain_pkg.sv */
// package: register map, field layout and timing for the analog input scaler
package ain_pkg;
	localparam logic [7:0] off_ctrl     = 8'h00;
	localparam logic [7:0] off_min      = 8'h04;
	localparam logic [7:0] off_max      = 8'h08;
	localparam logic [7:0] off_sample   = 8'h0c;
	localparam logic [7:0] off_result   = 8'h10;
	localparam logic [7:0] off_status   = 8'h14;
	localparam logic [7:0] off_dest_val = 8'h18;
	localparam logic [7:0] off_dest_wr  = 8'h1c;
	localparam int ctrl_dest_lsb = 0;
	localparam int ctrl_src_lsb  = 4;
	localparam logic [31:0] ctrl_reset = 32'h0000_0000;
	localparam logic [15:0] min_reset  = 16'h0000;
	localparam logic [15:0] max_reset  = 16'h00ff;
	localparam logic [7:0] cur_offset  = 8'h40;
	localparam int steps_volt = 256;
	localparam int steps_cur  = 192;
	localparam logic [7:0] pot_dead_band = 8'h02;
	localparam int settle_ms = 1000;
	localparam int clk_mhz   = 100;
	localparam int settle_cycles = settle_ms * 1000 * clk_mhz;

	typedef enum logic [2:0] {
		dest_none    = 3'b000,
		dest_target  = 3'b001,
		dest_percent = 3'b010,
		dest_program = 3'b011,
		dest_freqgen = 3'b100,
		dest_main_tach = 3'b101,
		dest_lead_tach = 3'b110
	} dest_t;

	typedef enum logic [1:0] {
		src_pot  = 2'b00,
		src_volt = 2'b01,
		src_cur  = 2'b10
	} src_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] value;
		dest_t       dest;
	} routed_t;
endpackage

/* File: src/ain_scale.sv */
// linear scaler from step index to value between min and max
`timescale 1ns/10ps
`default_nettype none
module ain_scale (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        in_valid,
	input  wire logic [7:0]  step_idx,
	input  wire logic [7:0]  step_last,
	input  wire logic [15:0] min_val,
	input  wire logic [15:0] max_val,
	output logic             out_valid,
	output logic [15:0]      out_val
);
	wire logic [15:0] span;
	wire logic [23:0] prod;
	wire logic [15:0] quot;
	wire logic [7:0]  idx_clip;

	// index clipped to top step
	assign idx_clip = (step_idx > step_last) ? step_last : step_idx;
	assign span = (max_val > min_val) ? max_val - min_val : 16'h0000;
	assign prod = span * idx_clip;
	assign quot = 16'((prod / {16'h0000, step_last}));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_valid <= 1'b0;
			out_val   <= 16'h0000;
		end else begin
			out_valid <= in_valid;
			if (in_valid)
				out_val <= min_val + quot;
		end
	end
endmodule
`default_nettype wire

/* File: src/analog_input_scaler_router.sv */
// analog input scaler and router with apb register file
`timescale 1ns/10ps
`default_nettype none
module analog_input_scaler_router #(
	parameter int settle_count = ain_pkg::settle_cycles
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        adc_valid,
	input  wire logic [8:0]  adc_code,
	input  wire logic        adc_under,
	input  wire logic        panel_wr,
	input  wire logic [15:0] panel_val,
	output var ain_pkg::routed_t route_out,
	output logic             nv_store
);
	logic [31:0] ctrl_reg;
	logic [15:0] min_reg;
	logic [15:0] max_reg;
	logic [7:0]  sample_reg;
	logic [15:0] result_reg;
	logic [15:0] dest_val_reg;
	logic        have_reg;
	logic [7:0]  pot_ref_reg;
	logic [31:0] settle_reg;
	logic        pend_reg;
	logic [7:0]  pend_idx_reg;
	logic        commit_reg;
	logic [7:0]  commit_idx_reg;
	logic        conv_fault_reg;

	wire ain_pkg::dest_t dest;
	wire ain_pkg::src_t  src;
	wire logic        wr_en;
	wire logic        rd_en;
	wire logic        addr_ok;
	wire logic        serial_wr;
	wire logic [7:0]  clamp_code;
	wire logic [7:0]  cur_shift;
	wire logic [15:0] cur_scaled;
	wire logic [7:0]  step_idx;
	wire logic [7:0]  step_last;
	wire logic        src_ok;
	wire logic [7:0]  pot_diff;
	wire logic        pot_big;
	wire logic        settled;
	wire logic        scale_go;
	wire logic [7:0]  scale_idx;
	wire logic        scale_valid;
	wire logic [15:0] scale_val;
	logic [31:0]      rd_mux;

	assign dest = ain_pkg::dest_t'(ctrl_reg[ain_pkg::ctrl_dest_lsb +: 3]);
	assign src  = ain_pkg::src_t'(ctrl_reg[ain_pkg::ctrl_src_lsb +: 2]);
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;
	assign addr_ok = (paddr == ain_pkg::off_ctrl) || (paddr == ain_pkg::off_min) ||
		(paddr == ain_pkg::off_max) || (paddr == ain_pkg::off_sample) ||
		(paddr == ain_pkg::off_result) || (paddr == ain_pkg::off_status) ||
		(paddr == ain_pkg::off_dest_val) || (paddr == ain_pkg::off_dest_wr);
	// serial write of the routed function value
	assign serial_wr = wr_en && pready && (paddr == ain_pkg::off_dest_wr);

	// clamp below zero and above full scale
	assign clamp_code = adc_under ? 8'h00 : (adc_code[8] ? 8'hff : adc_code[7:0]);
	// subtract fixed offset in current mode
	assign cur_shift = (clamp_code > ain_pkg::cur_offset) ? clamp_code - ain_pkg::cur_offset : 8'h00;
	assign cur_scaled = {8'h00, cur_shift};
	assign step_last = (src == ain_pkg::src_cur) ? 8'(ain_pkg::steps_cur - 1) : 8'(ain_pkg::steps_volt - 1);
	// current index saturates at the 20 mA step
	assign step_idx = (src == ain_pkg::src_cur) ?
		((cur_scaled > {8'h00, step_last}) ? step_last : cur_shift) : clamp_code;
	assign src_ok = (dest != ain_pkg::dest_freqgen) || (src == ain_pkg::src_pot);

	assign pot_diff = (step_idx > pot_ref_reg) ? step_idx - pot_ref_reg : pot_ref_reg - step_idx;
	assign pot_big  = pot_diff >= ain_pkg::pot_dead_band;
	assign settled  = pend_reg && (settle_reg == 32'(settle_count - 1)) && !(adc_valid && step_idx != pend_idx_reg);
	// voltage and current scale every sample, except when the destination is none or the frequency generator
	assign scale_go  = (src == ain_pkg::src_pot) ? commit_reg : (adc_valid && src_ok);
	assign scale_idx = (src == ain_pkg::src_pot) ? commit_idx_reg : step_idx;

	ain_scale u_scale (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (scale_go && dest != ain_pkg::dest_none),
		.step_idx  (scale_idx),
		.step_last (step_last),
		.min_val   (min_reg),
		.max_val   (max_reg),
		.out_valid (scale_valid),
		.out_val   (scale_val)
	);

	always_comb begin
		case (paddr)
			ain_pkg::off_ctrl:     rd_mux = ctrl_reg;
			ain_pkg::off_min:      rd_mux = {16'h0000, min_reg};
			ain_pkg::off_max:      rd_mux = {16'h0000, max_reg};
			ain_pkg::off_sample:   rd_mux = {24'h000000, sample_reg};
			ain_pkg::off_result:   rd_mux = {16'h0000, result_reg};
			ain_pkg::off_status:   rd_mux = {28'h0000000, conv_fault_reg, pend_reg, have_reg, src_ok};
			ain_pkg::off_dest_val: rd_mux = {16'h0000, dest_val_reg};
			ain_pkg::off_dest_wr:  rd_mux = 32'h0000_0000;
			default:               rd_mux = 32'h0000_0000;
		endcase
	end

	// apb slave: one wait-free access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok;
			if (rd_en)
				prdata <= rd_mux;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= ain_pkg::ctrl_reset;
			min_reg  <= ain_pkg::min_reset;
			max_reg  <= ain_pkg::max_reset;
		end else if (wr_en && pready) begin
			if (paddr == ain_pkg::off_ctrl)
				ctrl_reg <= {26'h0, pwdata[5:0]};
			if (paddr == ain_pkg::off_min)
				min_reg <= pwdata[15:0];
			if (paddr == ain_pkg::off_max)
				max_reg <= pwdata[15:0];
		end
	end

	// nothing held over reset, sample taken fresh
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample_reg     <= 8'h00;
			have_reg       <= 1'b0;
			conv_fault_reg <= 1'b0;
		end else if (adc_valid) begin
			sample_reg     <= step_idx;
			have_reg       <= 1'b1;
			conv_fault_reg <= !src_ok;
		end
	end

	// pot dead band and one second settle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pot_ref_reg    <= 8'h00;
			pend_reg       <= 1'b0;
			pend_idx_reg   <= 8'h00;
			settle_reg     <= 32'h0;
			commit_reg     <= 1'b0;
			commit_idx_reg <= 8'h00;
		end else begin
			commit_reg <= 1'b0;
			if (src != ain_pkg::src_pot) begin
				pend_reg       <= 1'b0;
				settle_reg     <= 32'h0;
			end else if (adc_valid && (!have_reg || pot_big || (pend_reg && step_idx != pend_idx_reg))) begin
				pend_reg       <= 1'b1;
				pend_idx_reg   <= step_idx;
				settle_reg     <= 32'h0;
			end else if (settled) begin
				pend_reg       <= 1'b0;
				settle_reg     <= 32'h0;
				pot_ref_reg    <= pend_idx_reg;
				commit_reg     <= 1'b1;
				commit_idx_reg <= pend_idx_reg;
			end else if (pend_reg) begin
				settle_reg <= settle_reg + 32'h1;
			end
		end
	end

	// single destination output and latest writer wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			route_out    <= '0;
			result_reg   <= 16'h0000;
			dest_val_reg <= 16'h0000;
			nv_store     <= 1'b0;
		end else begin
			route_out.valid <= 1'b0;
			route_out.dest  <= dest;
			nv_store        <= 1'b0;
			// panel or serial write overrides analog value
			if (panel_wr || serial_wr) begin
				dest_val_reg    <= panel_wr ? panel_val : pwdata[15:0];
				route_out.value <= panel_wr ? panel_val : pwdata[15:0];
				route_out.valid <= dest != ain_pkg::dest_none;
			end else if (scale_valid) begin
				result_reg      <= scale_val;
				dest_val_reg    <= scale_val;
				route_out.value <= scale_val;
				route_out.valid <= 1'b1;
				nv_store        <= src == ain_pkg::src_pot;
			end
		end
	end

	a_cur_full_max: assert property (@(posedge pclk) disable iff (!presetn)
		(adc_valid && src == ain_pkg::src_cur && adc_code[8] && !adc_under && src_ok && dest != ain_pkg::dest_none
		 && $stable(ctrl_reg)) |-> ##1 (scale_valid && scale_val == ((max_reg > min_reg) ? max_reg : min_reg)))
		else $error("current full scale not maximum");
	a_zero_gives_min: assert property (@(posedge pclk) disable iff (!presetn)
		(adc_valid && src == ain_pkg::src_volt && adc_under && src_ok && dest != ain_pkg::dest_none)
		|-> ##1 (scale_valid && scale_val == min_reg))
		else $error("zero input not minimum");
	a_freq_pot_only: assert property (@(posedge pclk) disable iff (!presetn)
		(dest == ain_pkg::dest_freqgen && src != ain_pkg::src_pot) |-> ##1 !scale_valid)
		else $error("non-pot reached frequency generator");
	a_volt_no_store: assert property (@(posedge pclk) disable iff (!presetn)
		(src == ain_pkg::src_volt && $stable(src)) |-> ##1 !nv_store)
		else $error("voltage value stored");
	a_result_bounds: assert property (@(posedge pclk) disable iff (!presetn)
		(scale_valid && max_reg >= min_reg && $stable(min_reg) && $stable(max_reg)) |-> (scale_val >= min_reg && scale_val <= max_reg))
		else $error("result outside min and max");
	a_pot_settle: assert property (@(posedge pclk) disable iff (!presetn)
		commit_reg |-> $past(pend_reg) && $past(settle_reg) == 32'(settle_count - 1))
		else $error("pot committed before settle");
	a_panel_wins: assert property (@(posedge pclk) disable iff (!presetn)
		(panel_wr && dest != ain_pkg::dest_none) |-> ##1 (route_out.valid && route_out.value == $past(panel_val)))
		else $error("panel write lost");
	// over range clamps to top step
	a_over_clamp: assert property (@(posedge pclk) disable iff (!presetn)
		(adc_valid && adc_code[8] && !adc_under && src != ain_pkg::src_cur) |-> ##1 sample_reg == 8'hff)
		else $error("over range not clamped");

	sequence s_volt_sample;
		(adc_valid && src != ain_pkg::src_pot && src_ok && dest != ain_pkg::dest_none) ##1 (!panel_wr && !serial_wr);
	endsequence
	sequence s_pot_commit;
		(commit_reg && src == ain_pkg::src_pot && dest != ain_pkg::dest_none) ##1 (!panel_wr && !serial_wr && src == ain_pkg::src_pot);
	endsequence
	// every voltage or current sample with a destination and a valid source routed, unless a panel or serial write follows
	a_volt_tracks: assert property (@(posedge pclk) disable iff (!presetn)
		s_volt_sample |-> ##1 (route_out.valid && route_out.value == $past(scale_val)))
		else $error("analog sample not routed");
	a_pot_store: assert property (@(posedge pclk) disable iff (!presetn)
		s_pot_commit |-> ##1 (nv_store && route_out.value == $past(scale_val)))
		else $error("pot commit not stored");
	a_pot_dead_band: assert property (@(posedge pclk) disable iff (!presetn)
		(adc_valid && src == ain_pkg::src_pot && have_reg && !pend_reg && !pot_big) |=> !pend_reg)
		else $error("pot reacted inside dead band");
	// current at or below offset gives minimum
	a_cur_low_min: assert property (@(posedge pclk) disable iff (!presetn)
		((adc_valid && src == ain_pkg::src_cur && !adc_code[8] && adc_code[7:0] <= ain_pkg::cur_offset && src_ok
		  && dest != ain_pkg::dest_none) ##1 $stable(min_reg)) |-> (scale_valid && scale_val == min_reg))
		else $error("low current not minimum");
	a_serial_wins: assert property (@(posedge pclk) disable iff (!presetn)
		(serial_wr && !panel_wr && dest != ain_pkg::dest_none) |=> (route_out.valid && route_out.value == $past(pwdata[15:0])))
		else $error("serial write lost");
	a_cfg_min_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && pready && paddr == ain_pkg::off_min) |=> (min_reg == $past(pwdata[15:0])))
		else $error("minimum write lost");
	a_none_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		(dest == ain_pkg::dest_none && $stable(ctrl_reg)) |=> !route_out.valid)
		else $error("route with no destination");
endmodule
`default_nettype wire

/* File: testbench/ain_source.sv */
// analog signal source model driving the converter sample port
`timescale 1ns/10ps
`default_nettype none
module ain_source (
	input  wire logic  pclk,
	output logic       adc_valid,
	output logic [8:0] adc_code,
	output logic       adc_under
);
	initial begin
		adc_valid = 1'b0;
		adc_code  = 9'h000;
		adc_under = 1'b0;
	end
	// one sample; afterwards the lines stop showing it
	task automatic send(input logic [8:0] c, input logic u);
		adc_valid <= 1'b1;
		adc_code  <= c;
		adc_under <= u;
		@(posedge pclk);
		adc_valid <= 1'b0;
		adc_code  <= ~c;
		adc_under <= ~u;
	endtask
endmodule
`default_nettype wire

/* File: testbench/test_analog_input_scaler_router.sv */
// self-checking bench for the analog input scaler and router
`timescale 1ns/10ps
`default_nettype none
module test_analog_input_scaler_router;
	logic             pclk = 1'b0;
	logic             presetn = 1'b0;
	logic             psel = 1'b0;
	logic             penable = 1'b0;
	logic             pwrite = 1'b0;
	logic [7:0]       paddr = 8'h00;
	logic [31:0]      pwdata = 32'h0;
	logic [31:0]      prdata;
	logic             pready;
	logic             pslverr;
	logic             adc_valid;
	logic [8:0]       adc_code;
	logic             adc_under;
	logic             panel_wr = 1'b0;
	logic [15:0]      panel_val = 16'h0;
	ain_pkg::routed_t route_out;
	logic             nv_store;
	logic [15:0]      last_val = 16'h0;
	logic [2:0]       last_dest = 3'h0;
	int               n_route = 0;
	int               n_nv = 0;
	int               error_cnt = 0;
	int               n_compared = 0;
	int               st;
	logic [31:0]      rd;
	logic             er;
	logic [8:0]       vc [10] = '{9'h000, 9'h0ff, 9'h080, 9'h100, 9'h055, 9'h040, 9'h020, 9'h0ff, 9'h0a0, 9'h100};
	logic             vu [10] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
	logic [15:0]      ve [10] = '{16'h0064, 16'h03e8, 16'h0227, 16'h03e8, 16'h0064,
		16'h0064, 16'h0064, 16'h03e8, 16'h0228, 16'h03e8};

	always #5 pclk = ~pclk;

	analog_input_scaler_router #(.settle_count(20)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.adc_valid(adc_valid), .adc_code(adc_code), .adc_under(adc_under), .panel_wr(panel_wr),
		.panel_val(panel_val), .route_out(route_out), .nv_store(nv_store)
	);
	ain_source src_u (.pclk(pclk), .adc_valid(adc_valid), .adc_code(adc_code), .adc_under(adc_under));

	always @(posedge pclk) begin
		if (route_out.valid === 1'b1) begin
			last_val  <= route_out.value;
			last_dest <= route_out.dest;
			n_route   <= n_route + 1;
		end
		if (nv_store === 1'b1) begin
			n_nv <= n_nv + 1;
		end
	end

	task automatic complete_run;
		if (error_cnt == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// apb transfer, entered just after a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			error_cnt++;
			complete_run();
		end
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	function automatic logic [31:0] cw(ain_pkg::src_t s, ain_pkg::dest_t d);
		return {26'h0, s, 1'b0, d};
	endfunction

	task automatic wait_route(input int start, input logic [15:0] exp, input logic [2:0] dst);
		for (int i = 0; i < 60 && n_route == start; i++) @(posedge pclk);
		if (n_route == start) begin
			error_cnt++;
			complete_run();
		end
		check(n_route - start, 1);
		check({16'h0, last_val}, {16'h0, exp});
		check({29'h0, last_dest}, {29'h0, dst});
	endtask

	task automatic smp(input logic [8:0] c, input logic u, input logic [15:0] exp, input logic [2:0] dst);
		st = n_route;
		src_u.send(c, u);
		wait_route(st, exp, dst);
	endtask

	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		complete_run();
	end

	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 8'h40, 32'h0);
		check({31'h0, er}, 32'h1);
		check(rd, 32'h0);
		apb(1'b1, ain_pkg::off_min, 32'h0064);
		apb(1'b1, ain_pkg::off_max, 32'h03e8);
		for (int i = 0; i < 10; i++) begin
			if (i == 0) apb(1'b1, ain_pkg::off_ctrl, cw(ain_pkg::src_volt, ain_pkg::dest_target));
			if (i == 5) apb(1'b1, ain_pkg::off_ctrl, cw(ain_pkg::src_cur, ain_pkg::dest_percent));
			smp(vc[i], vu[i], ve[i], (i < 5) ? 3'h1 : 3'h2);
		end
		check(n_nv, 0);
		for (int d = 0; d < 7; d++) begin
			apb(1'b1, ain_pkg::off_ctrl, cw(ain_pkg::src_volt, ain_pkg::dest_t'(d)));
			st = n_route;
			src_u.send(9'h0ff, 1'b0);
			repeat (10) @(posedge pclk);
			check(n_route - st, (d == 0 || d == 4) ? 0 : 1);
			if (d != 0 && d != 4) check({29'h0, last_dest}, 32'(d));
		end
		apb(1'b1, ain_pkg::off_ctrl, cw(ain_pkg::src_volt, ain_pkg::dest_target));
		st = n_route;
		panel_val <= 16'h1234;
		panel_wr  <= 1'b1;
		@(posedge pclk);
		panel_wr  <= 1'b0;
		wait_route(st, 16'h1234, 3'h1);
		smp(9'h000, 1'b0, 16'h0064, 3'h1);
		apb(1'b1, ain_pkg::off_dest_wr, 32'h0777);
		apb(1'b0, ain_pkg::off_dest_val, 32'h0);
		check(rd, 32'h0777);
		check({31'h0, er}, 32'h0);
		apb(1'b1, ain_pkg::off_ctrl, cw(ain_pkg::src_pot, ain_pkg::dest_freqgen));
		st = n_route;
		src_u.send(9'h0c8, 1'b0);
		repeat (10) @(posedge pclk);
		check(n_route - st, 0);
		wait_route(st, 16'h0325, 3'h4);
		check(n_nv, 1);
		st = n_route;
		src_u.send(9'h0c9, 1'b0);
		repeat (40) @(posedge pclk);
		check(n_route - st, 0);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, ain_pkg::off_ctrl, 32'h0);
		check(rd, ain_pkg::ctrl_reset);
		apb(1'b0, ain_pkg::off_max, 32'h0);
		check(rd, {16'h0, ain_pkg::max_reset});
		apb(1'b0, ain_pkg::off_min, 32'h0);
		check(rd, {16'h0, ain_pkg::min_reset});
		apb(1'b1, ain_pkg::off_ctrl, cw(ain_pkg::src_volt, ain_pkg::dest_main_tach));
		smp(9'h0ff, 1'b0, 16'h00ff, 3'h5);
		complete_run();
	end
endmodule
`default_nettype wire
